// file: rtl/irq_enable_pkg.sv
// Purpose: Constants, types and decode helper for the interrupt enable bank
// Assumes: Registers reached over Avalon-MM, byte addresses, 32-bit data
// Notes:   Enable words are 16 bits wide and sit in the low half of a word
package irq_enable_pkg;

  localparam int WORD_W    = 16;
  localparam int NUM_WORDS = 3;
  localparam int EVT_W     = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_EN0    = 5'h00;
  localparam logic [4:0] OFS_EN1    = 5'h04;
  localparam logic [4:0] OFS_EN2    = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_MASK   = 5'h10;

  // ----------------------------------------------------------------
  // Source bit positions
  // ----------------------------------------------------------------
  localparam int BIT_EXT_PIN0    = 0;
  localparam int BIT_CAPTURE1    = 1;
  localparam int BIT_I2C1_SLAVE  = 0;
  localparam int BIT_I2C1_MASTER = 1;
  localparam int BIT_COMPARATOR  = 2;
  localparam int BIT_PIN_CHANGE  = 3;
  localparam int BIT_EXT_PIN1    = 4;
  localparam int BIT_COMPARE3    = 9;
  localparam int BIT_TIMER4      = 11;
  localparam int BIT_TIMER5      = 12;
  localparam int BIT_EXT_PIN2    = 13;
  localparam int BIT_SERIAL2_RX  = 14;
  localparam int BIT_SERIAL2_TX  = 15;
  localparam int BIT_SPI2_FAULT  = 0;
  localparam int BIT_SPI2_EVENT  = 1;
  localparam int BIT_CAPTURE3    = 5;

  // Implemented bits of each enable word, index 0 is the first word
  localparam logic [NUM_WORDS-1:0][WORD_W-1:0] IMPL_MASK = {16'h0023, 16'hFA1F, 16'hBFEF};

  localparam logic [WORD_W-1:0] EN_RESET  = 16'h0000;
  localparam logic [EVT_W-1:0]  EVT_RESET = 3'h0;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_DECERR = 2'h3;

  typedef enum {SEL_EN0, SEL_EN1, SEL_EN2, SEL_STATUS, SEL_MASK, SEL_NONE} reg_sel_t;
  typedef enum {BUS_IDLE, BUS_ACK} bus_phase_t;

  function automatic reg_sel_t reg_decode(input logic [4:0] addr);
    case (addr)
      OFS_EN0:    return SEL_EN0;
      OFS_EN1:    return SEL_EN1;
      OFS_EN2:    return SEL_EN2;
      OFS_STATUS: return SEL_STATUS;
      OFS_MASK:   return SEL_MASK;
      default:    return SEL_NONE;
    endcase
  endfunction

endpackage

// file: rtl/irq_gate_word.sv
// Purpose: Gates one word of interrupt requests by its enable bits
// Assumes: Requests come from logic on the same clock
// Notes:   One cycle of latency; the output is a flip-flop
`timescale 1ns/1ps
module irq_gate_word #(
  parameter logic [15:0] IMPL = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Requests and enables
  input  wire logic [15:0] req,
  input  wire logic [15:0] en,
  // Gated requests
  output logic      [15:0] gated
);
  import irq_enable_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] gated;
  } gate_state_t;

  gate_state_t s_r;
  gate_state_t s_nxt;

  // Unimplemented positions never pass, whatever the enable holds
  always_comb begin
    s_nxt       = s_r;
    s_nxt.gated = req & en & IMPL;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r.gated <= EN_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign gated = s_r.gated;

endmodule // irq_gate_word

// file: rtl/interrupt_enable_bank.sv
// Purpose: Software enable bits that gate peripheral interrupt requests
// Assumes: Avalon-MM slave with waitrequest, requests on the same clock
// Notes:   Summary of rules below; status collects word activity, mask selects which status bits raise irq
//
// Summary of operation
// - Set enable passes request, clear blocks it
// - Unimplemented bits read zero, ignore writes
// - Word0 bit1 gates input capture one
// - Word0 bit0 gates external pin zero
// - Word1 bit1 gates I2C1 master events
// - Word1 bit0 gates I2C1 slave events
// - Word2 bit5 gates input capture three
// - Word2 bit1 gates SPI2 event request
// - Word2 bit0 gates SPI2 fault request
`timescale 1ns/1ps
module interrupt_enable_bank (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic      [1:0]  avs_response,
  output logic             avs_waitrequest,
  // Raw requests from the sources
  input  wire logic [15:0] req_word0,
  input  wire logic [15:0] req_word1,
  input  wire logic [15:0] req_word2,
  // Gated requests to the processor
  output logic      [15:0] gated_word0,
  output logic      [15:0] gated_word1,
  output logic      [15:0] gated_word2,
  // Summary interrupt
  output logic             irq
);
  import irq_enable_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bus_phase_t                        phase;
    logic                              waitreq;
    logic [31:0]                       rdata;
    logic [1:0]                        resp;
    logic [NUM_WORDS-1:0][WORD_W-1:0]  en;
    logic [EVT_W-1:0]                  status;
    logic [EVT_W-1:0]                  mask;
    logic                              irq;
  } bank_state_t;

  bank_state_t s_r;
  bank_state_t s_nxt;

  reg_sel_t                         sel;
  logic                             commit;
  logic [NUM_WORDS-1:0][WORD_W-1:0] req_w;
  logic [NUM_WORDS-1:0][WORD_W-1:0] gated_w;
  logic [EVT_W-1:0]                 evt_set;
  logic [EVT_W-1:0]                 evt_clr;

  assign req_w = {req_word2, req_word1, req_word0};

  // ----------------------------------------------------------------
  // Gating, one instance per enable word
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < NUM_WORDS; k++) begin : g_word
      irq_gate_word #(
        .IMPL (IMPL_MASK[k])
      ) u_gate (
        .clk   (clk),
        .reset (reset),
        .req   (req_w[k]),
        .en    (s_r.en[k]),
        .gated (gated_w[k])
      );
      assign evt_set[k] = |gated_w[k];
    end
  endgenerate

  // Byte-lane merge for 16-bit registers; lanes 3:2 carry nothing here
  function automatic logic [WORD_W-1:0] lane_merge(input logic [WORD_W-1:0] old_v,
                                                   input logic [31:0]       wdata,
                                                   input logic [3:0]        be);
    logic [WORD_W-1:0] v;
    v = old_v;
    if (be[0]) begin
      v[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      v[15:8] = wdata[15:8];
    end
    return v;
  endfunction

  // Read value of a register, upper half always zero
  function automatic logic [31:0] read_mux(input reg_sel_t    rs,
                                           input bank_state_t st);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (rs)
      SEL_EN0:    r[WORD_W-1:0] = st.en[0];
      SEL_EN1:    r[WORD_W-1:0] = st.en[1];
      SEL_EN2:    r[WORD_W-1:0] = st.en[2];
      SEL_STATUS: r[EVT_W-1:0]  = st.status;
      SEL_MASK:   r[EVT_W-1:0]  = st.mask;
      default:    r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A request is accepted in IDLE and answered one cycle later; the
  // write lands on the edge where waitrequest is sampled low.
  // Read data is taken one edge early, so a read right after a write
  // still sees the new value: the write lands before the next take.
  always_comb begin
    s_nxt   = s_r;
    sel     = reg_decode(avs_address);
    commit  = (s_r.phase == BUS_ACK) && avs_write;
    evt_clr = '0;

    case (s_r.phase)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_nxt.phase   = BUS_ACK;
          s_nxt.waitreq = 1'b0;
          s_nxt.rdata   = avs_read ? read_mux(sel, s_r) : 32'h0000_0000;
          s_nxt.resp    = (sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
      end
      BUS_ACK: begin
        s_nxt.phase   = BUS_IDLE;
        s_nxt.waitreq = 1'b1;
      end
      default: begin
        s_nxt.phase   = BUS_IDLE;
        s_nxt.waitreq = 1'b1;
      end
    endcase

    if (commit) begin
      case (sel)
        SEL_EN0: begin
          s_nxt.en[0] = lane_merge(s_r.en[0], avs_writedata, avs_byteenable)
                        & IMPL_MASK[0];
        end
        SEL_EN1: begin
          s_nxt.en[1] = lane_merge(s_r.en[1], avs_writedata, avs_byteenable)
                        & IMPL_MASK[1];
        end
        SEL_EN2: begin
          s_nxt.en[2] = lane_merge(s_r.en[2], avs_writedata, avs_byteenable)
                        & IMPL_MASK[2];
        end
        SEL_STATUS: begin
          evt_clr = avs_writedata[EVT_W-1:0] & {EVT_W{avs_byteenable[0]}};
        end
        SEL_MASK: begin
          if (avs_byteenable[0]) begin
            s_nxt.mask = avs_writedata[EVT_W-1:0];
          end
        end
        default: begin
          s_nxt.mask = s_r.mask;
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear
    s_nxt.status = (s_r.status & ~evt_clr) | evt_set;
    s_nxt.irq    = |(s_nxt.status & s_nxt.mask);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r.phase   <= BUS_IDLE;
      s_r.waitreq <= 1'b1;
      s_r.rdata   <= 32'h0000_0000;
      s_r.resp    <= RESP_OKAY;
      s_r.en      <= {NUM_WORDS{EN_RESET}};
      s_r.status  <= EVT_RESET;
      s_r.mask    <= EVT_RESET;
      s_r.irq     <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata    = s_r.rdata;
  assign avs_response    = s_r.resp;
  assign avs_waitrequest = s_r.waitreq;
  assign gated_word0     = gated_w[0];
  assign gated_word1     = gated_w[1];
  assign gated_word2     = gated_w[2];
  assign irq             = s_r.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Positions of the second word, rebuilt from the named bits
  localparam logic [WORD_W-1:0] POS_MASK1 =
    WORD_W'((1 << BIT_SERIAL2_TX) | (1 << BIT_SERIAL2_RX) | (1 << BIT_EXT_PIN2) |
            (1 << BIT_TIMER5) | (1 << BIT_TIMER4) | (1 << BIT_COMPARE3) |
            (1 << BIT_EXT_PIN1) | (1 << BIT_PIN_CHANGE) | (1 << BIT_COMPARATOR) |
            (1 << BIT_I2C1_MASTER) | (1 << BIT_I2C1_SLAVE));

  property p_gate_pass;
    !$past(reset) |-> {gated_word2, gated_word1, gated_word0} ==
                      $past({req_word2, req_word1, req_word0} & s_r.en);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("gated request mismatch");

  property p_unimpl_read;
    (s_r.phase == BUS_ACK && $past(avs_read) && reg_decode(avs_address) == SEL_EN2) |->
      (avs_readdata[WORD_W-1:0] & ~IMPL_MASK[2]) == '0 && avs_readdata[31:WORD_W] == '0;
  endproperty
  a_unimpl_read: assert property (p_unimpl_read) else $error("hole bits read nonzero");

  property p_capture1;
    $past(req_word0[BIT_CAPTURE1] && s_r.en[0][BIT_CAPTURE1]) && !$past(reset)
      |-> gated_word0[BIT_CAPTURE1];
  endproperty
  a_capture1: assert property (p_capture1) else $error("capture one not passed");

  property p_ext_pin0;
    (commit && sel == SEL_EN0 && avs_byteenable[0] && avs_writedata[BIT_EXT_PIN0])
      ##1 req_word0[BIT_EXT_PIN0] |=> gated_word0[BIT_EXT_PIN0];
  endproperty
  a_ext_pin0: assert property (p_ext_pin0) else $error("pin zero not passed");

  property p_i2c1_master;
    !s_r.en[1][BIT_I2C1_MASTER] |=> !gated_word1[BIT_I2C1_MASTER];
  endproperty
  a_i2c1_master: assert property (p_i2c1_master) else $error("i2c master leaked");

  property p_i2c1_slave;
    (req_word1[BIT_I2C1_SLAVE] && s_r.en[1][BIT_I2C1_SLAVE])[*2] |-> gated_word1[BIT_I2C1_SLAVE];
  endproperty
  a_i2c1_slave: assert property (p_i2c1_slave) else $error("i2c slave not passed");

  property p_capture3;
    $rose(gated_word2[BIT_CAPTURE3]) |-> $past(s_r.en[2][BIT_CAPTURE3]);
  endproperty
  a_capture3: assert property (p_capture3) else $error("capture three without enable");

  property p_spi2_event;
    !$past(reset) && gated_word2[BIT_SPI2_EVENT] |-> $past(req_word2[BIT_SPI2_EVENT]);
  endproperty
  a_spi2_event: assert property (p_spi2_event) else $error("spi event without request");

  property p_spi2_fault;
    (commit && sel == SEL_EN2 && avs_byteenable[0] && !avs_writedata[BIT_SPI2_FAULT])
      |=> ##1 !gated_word2[BIT_SPI2_FAULT];
  endproperty
  a_spi2_fault: assert property (p_spi2_fault) else $error("spi fault leaked");

  property p_word1_pos;
    (commit && sel == SEL_EN1 && avs_byteenable[1:0] == 2'h3)
      |=> s_r.en[1] == ($past(avs_writedata[WORD_W-1:0]) & POS_MASK1);
  endproperty
  a_word1_pos: assert property (p_word1_pos) else $error("word one layout wrong");

  property p_reset_clear;
    $past(reset) |-> s_r.en == '0 ##1 {gated_word2, gated_word1, gated_word0} == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not clear");

  property p_bus_answer;
    (s_r.phase == BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

  property p_irq_level;
    irq == |(s_r.status & s_r.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

  // ----------------------------------------------------------------
  // Register and event integrity
  // ----------------------------------------------------------------
  // Writes are masked on the way in, so a stored one in a hole means a
  // mask constant and the bit layout have drifted apart.
  property p_unimpl_store;
    (s_r.en & ~IMPL_MASK) == '0;
  endproperty
  a_unimpl_store: assert property (p_unimpl_store) else $error("hole bit stored");

  // Software sees only the low half; the upper half never carries data
  property p_read_upper;
    !avs_waitrequest |-> avs_readdata[31:WORD_W] == '0;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read half nonzero");

  // An unmapped address is answered, not hung, so software can recover
  property p_decerr;
    (s_r.phase == BUS_IDLE && (avs_read || avs_write) && sel == SEL_NONE)
      |=> avs_response == RESP_DECERR && avs_readdata == '0;
  endproperty
  a_decerr: assert property (p_decerr) else $error("unmapped access not refused");

  property p_unmapped_write;
    (commit && sel == SEL_NONE) |=> s_r.en == $past(s_r.en) && s_r.mask == $past(s_r.mask);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  property p_word0_write;
    (commit && sel == SEL_EN0 && avs_byteenable[1:0] == 2'h3)
      |=> s_r.en[0] == ($past(avs_writedata[WORD_W-1:0]) & IMPL_MASK[0]);
  endproperty
  a_word0_write: assert property (p_word0_write) else $error("word zero write lost");

  // Status is sticky: only a status write may lower a bit, and an event
  // in that same cycle keeps its bit, so no request is ever lost
  property p_status_set;
    (|evt_set) |=> (s_r.status & $past(evt_set)) == $past(evt_set);
  endproperty
  a_status_set: assert property (p_status_set) else $error("event not recorded");

  property p_status_sticky;
    !(commit && sel == SEL_STATUS) |=> (s_r.status & $past(s_r.status)) == $past(s_r.status);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit dropped");

  c_read_en:  cover property (s_r.phase == BUS_ACK && avs_read && sel == SEL_EN0);
  c_write_en: cover property (commit && sel == SEL_EN2);
  c_decerr:   cover property (!avs_waitrequest && avs_response == RESP_DECERR);
  c_irq:      cover property ($rose(irq));
  c_irq_drop: cover property ($fell(irq));

endmodule // interrupt_enable_bank

// file: sim/irq_source_model.sv
// Purpose: Behavioural model of the peripheral sources that raise requests
// Assumes: Sources run on the same clock as the enable bank
// Notes:   slow adds one cycle of lag, as a source behind a pipeline would
`timescale 1ns/1ps
module irq_source_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Commands from the bench
  input  wire logic        slow,
  input  wire logic [15:0] pattern0,
  input  wire logic [15:0] pattern1,
  input  wire logic [15:0] pattern2,
  // Requests toward the bank
  output logic      [15:0] req_word0,
  output logic      [15:0] req_word1,
  output logic      [15:0] req_word2
);
  logic [47:0] stage_r;
  logic [47:0] lag_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage_r <= 48'h0;
      lag_r   <= 48'h0;
    end else begin
      stage_r <= {pattern2, pattern1, pattern0};
      lag_r   <= stage_r;
    end
  end

  // Sources share the reset, so they stay quiet through it
  assign {req_word2, req_word1, req_word0} = slow ? lag_r : stage_r;
endmodule // irq_source_model

// file: sim/tb.sv
// Purpose: Self-checking bench for the interrupt enable bank
// Assumes: Avalon-MM master tasks; source model on the request side
// Notes:   Reset state first, then table of register rows, gating, interrupt and reset cases
`timescale 1ns/1ps
module tb;
  import irq_enable_pkg::*;

  typedef struct packed {
    logic [4:0]  a;
    logic [31:0] d;
    logic [3:0]  be;
    logic [31:0] exp;
    logic [1:0]  rs;
  } row_t;

  localparam logic [4:0] EN_OFS [3] = '{OFS_EN0, OFS_EN1, OFS_EN2};

  logic        clk            = 1'b0;
  logic        reset          = 1'b1;
  logic [4:0]  avs_address    = 5'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic [1:0]  avs_response;
  logic        avs_waitrequest;
  logic [15:0] req [3];
  logic [15:0] g [3];
  logic [15:0] pat [3]        = '{16'h0, 16'h0, 16'h0};
  logic        slow           = 1'b0;
  logic        irq;
  logic [31:0] rd_v;
  logic [1:0]  rs_v;
  int          n_mismatch     = 0;
  int          checks_done    = 0;
  row_t        rows [9];

  always #10 clk = ~clk;

  irq_source_model u_irq_source_model (.clk(clk), .reset(reset), .slow(slow),
    .pattern0(pat[0]), .pattern1(pat[1]), .pattern2(pat[2]),
    .req_word0(req[0]), .req_word1(req[1]), .req_word2(req[2]));

  interrupt_enable_bank u_interrupt_enable_bank (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .req_word0(req[0]), .req_word1(req[1]),
    .req_word2(req[2]), .gated_word0(g[0]), .gated_word1(g[1]), .gated_word2(g[2]),
    .irq(irq));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; a hung slave ends the run
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int i;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr_en;
    avs_read       <= ~wr_en;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      rd_v = avs_readdata;
      rs_v = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdr(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic solo(input int w, input int b);
    wr(EN_OFS[w], 32'h1 << b);
    gap(3);
  endtask

  task automatic check_idle();
    for (int k = 0; k < 3; k++) begin
      rdr(EN_OFS[k]);
      chk("enable_word", rd_v, 32'h0);
      chk("gated_word", 32'(g[k]), 32'h0);
    end
    rdr(OFS_STATUS);
    chk("status", rd_v, 32'h0);
    rdr(OFS_MASK);
    chk("mask", rd_v, 32'h0);
    chk("irq", 32'(irq), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = '{OFS_EN0, 32'hFFFFFFFF, 4'hF, 32'h0000BFEF, RESP_OKAY};
    rows[1] = '{OFS_EN1, 32'hFFFFFFFF, 4'hF, 32'h0000FA1F, RESP_OKAY};
    rows[2] = '{OFS_EN2, 32'hFFFFFFFF, 4'hF, 32'h00000023, RESP_OKAY};
    rows[3] = '{OFS_EN2, 32'h00000000, 4'hF, 32'h00000000, RESP_OKAY};
    rows[4] = '{OFS_EN1, 32'h00005A5A, 4'h1, 32'h0000FA1A, RESP_OKAY};
    rows[5] = '{OFS_EN0, 32'h00000000, 4'h2, 32'h000000EF, RESP_OKAY};
    rows[6] = '{5'h14, 32'hFFFFFFFF, 4'hF, 32'h00000000, RESP_DECERR};
    rows[7] = '{OFS_EN0, 32'h00000000, 4'hF, 32'h00000000, RESP_OKAY};
    rows[8] = '{OFS_EN1, 32'h00000000, 4'hF, 32'h00000000, RESP_OKAY};
    gap(8);
    reset <= 1'b0;
    gap(1);
    check_idle();
    $display("test reset_state done");
    for (int r = 0; r < 9; r++) begin
      bus(1'b1, rows[r].a, rows[r].d, rows[r].be);
      chk("write_resp", 32'(rs_v), 32'(rows[r].rs));
      rdr(rows[r].a);
      chk("readback", rd_v, rows[r].exp);
      chk("read_resp", 32'(rs_v), 32'(rows[r].rs));
    end
    $display("test register_rows done");
    // Other words keep requests high so a leak into the next word, wrapping from word2 to word0, shows up
    pat <= '{16'hFFFF, 16'hFFFF, 16'hFFFF};
    for (int w = 0; w < 3; w++) begin
      for (int b = 0; b < 16; b++) begin
        wr(EN_OFS[w], 32'h1 << b);
        gap(3);
        chk("gated_pass", 32'(g[w]), 32'(IMPL_MASK[w] & (16'h1 << b)));
        chk("gated_other", 32'(g[(w + 1) % 3]), 32'h0);
        pat[w] <= ~(16'h1 << b);
        gap(3);
        chk("gated_req_off", 32'(g[w]), 32'h0);
        pat[w] <= 16'hFFFF;
      end
      wr(EN_OFS[w], 32'h0);
      gap(3);
      chk("gated_blocked", 32'(g[w]), 32'h0);
    end
    $display("test gating_walk done");
    // Each source in the bank's summary alone, its position taken from its own constant
    solo(0, BIT_CAPTURE1);
    chk("capture1", 32'(g[0]), 32'(16'h1 << BIT_CAPTURE1));
    solo(0, BIT_EXT_PIN0);
    chk("ext_pin0", 32'(g[0]), 32'(16'h1 << BIT_EXT_PIN0));
    solo(1, BIT_I2C1_MASTER);
    chk("i2c1_master", 32'(g[1]), 32'(16'h1 << BIT_I2C1_MASTER));
    solo(1, BIT_I2C1_SLAVE);
    chk("i2c1_slave", 32'(g[1]), 32'(16'h1 << BIT_I2C1_SLAVE));
    solo(2, BIT_CAPTURE3);
    chk("capture3", 32'(g[2]), 32'(16'h1 << BIT_CAPTURE3));
    solo(2, BIT_SPI2_EVENT);
    chk("spi2_event", 32'(g[2]), 32'(16'h1 << BIT_SPI2_EVENT));
    solo(2, BIT_SPI2_FAULT);
    chk("spi2_fault", 32'(g[2]), 32'(16'h1 << BIT_SPI2_FAULT));
    for (int w = 0; w < 3; w++) begin
      wr(EN_OFS[w], 32'h0);
    end
    $display("test named_bits done");
    pat <= '{16'h0, 16'h0, 16'h0};
    gap(3);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_MASK, 32'h2);
    wr(EN_OFS[1], 32'h8);
    slow    <= 1'b1;
    pat[1]  <= 16'h0008;
    gap(6);
    rdr(OFS_STATUS);
    chk("status_set", rd_v, 32'h2);
    chk("irq_raised", 32'(irq), 32'h1);
    pat[1] <= 16'h0;
    gap(4);
    wr(OFS_STATUS, 32'h2);
    gap(3);
    chk("irq_cleared", 32'(irq), 32'h0);
    wr(EN_OFS[2], 32'h1);
    pat[2] <= 16'h0001;
    gap(6);
    rdr(OFS_STATUS);
    chk("status_masked", rd_v, 32'h4);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_MASK, 32'h6);
    gap(3);
    chk("irq_unmasked", 32'(irq), 32'h1);
    // Clear while the event is still active: the event must win
    wr(OFS_STATUS, 32'h4);
    rdr(OFS_STATUS);
    chk("status_set_wins", rd_v, 32'h4);
    $display("test interrupt done");
    // Reset in mid-run with a request still active
    reset <= 1'b1;
    gap(2);
    reset <= 1'b0;
    gap(1);
    check_idle();
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule // tb
